// ==== rtl/wcx_pkg.sv ====
package wcx_pkg;

	// Register map of the plain register port.
	localparam logic [7:0] WCX_OFS_CMD = 8'h00;
	localparam logic [7:0] WCX_OFS_WX = 8'h04;
	localparam logic [7:0] WCX_OFS_RX = 8'h08;
	localparam logic [7:0] WCX_OFS_STATUS = 8'h0c;
	localparam logic [7:0] WCX_OFS_CALINFO = 8'h10;

	// Status register field positions.
	localparam int WCX_ST_CELL = 0;
	localparam int WCX_ST_ADC = 1;
	localparam int WCX_ST_MAX9 = 2;
	localparam int WCX_ST_FS110 = 3;
	localparam int WCX_ST_GROSS_RNG = 4;
	localparam int WCX_ST_NET_RNG = 5;
	localparam int WCX_ST_UNDER = 6;
	localparam int WCX_ST_GROSS_NEG = 7;
	localparam int WCX_ST_NET_NEG = 8;
	localparam int WCX_ST_PEAK_NEG = 9;
	localparam int WCX_ST_NET_MODE = 10;
	localparam int WCX_ST_STABLE = 11;
	localparam int WCX_ST_NEAR_ZERO = 12;
	localparam int WCX_ST_ALIVE = 15;

	// Calibration info register field positions.
	localparam int WCX_CI_REJECT = 8;
	localparam int WCX_CI_GRANTED = 16;

	// Weight limits and factors.
	localparam logic signed [39:0] WCX_RANGE_MAX = 40'sd999999;
	localparam logic signed [39:0] WCX_RANGE_MIN = -40'sd999999;
	localparam logic [39:0] WCX_MAX_OVER_DIV = 40'd9;
	localparam logic [39:0] WCX_UNDER_DIV = 40'd20;
	localparam logic [39:0] WCX_FS_NUM = 40'd11;
	localparam logic [39:0] WCX_FS_DEN = 40'd10;
	localparam logic [39:0] WCX_ZERO_QUART = 40'd4;
	localparam int WCX_CAL_POINTS = 8;

	// Alive indication timing.
	localparam int WCX_CLK_KHZ = 25000;
	localparam int WCX_ALIVE_MS = 1000;
	localparam int WCX_ALIVE_CYCLES = WCX_ALIVE_MS * WCX_CLK_KHZ;

	// Reset values.
	localparam logic [31:0] WCX_SEED_RESET = 32'h0000_0001;
	// Arbitrary access key mixed into the expected password.
	localparam logic [31:0] WCX_ACCESS_KEY = 32'h5a3c_96e1;

	// Command codes.
	localparam logic [15:0] WCX_C_NONE = 16'h0000;
	localparam logic [15:0] WCX_C_TARE_ON = 16'h0007;
	localparam logic [15:0] WCX_C_ZERO = 16'h0008;
	localparam logic [15:0] WCX_C_TARE_OFF = 16'h0009;
	localparam logic [15:0] WCX_C_KEY_LOCK = 16'h0015;
	localparam logic [15:0] WCX_C_UNLOCK = 16'h0016;
	localparam logic [15:0] WCX_C_ALL_LOCK = 16'h0017;
	localparam logic [15:0] WCX_C_PT_RD = 16'h0057;
	localparam logic [15:0] WCX_C_PT_WR = 16'h0058;
	localparam logic [15:0] WCX_C_SP1_RD = 16'h005a;
	localparam logic [15:0] WCX_C_SP2_RD = 16'h005b;
	localparam logic [15:0] WCX_C_SP3_RD = 16'h005c;
	localparam logic [15:0] WCX_C_SP1_WR = 16'h005d;
	localparam logic [15:0] WCX_C_SP2_WR = 16'h005e;
	localparam logic [15:0] WCX_C_SP3_WR = 16'h005f;
	localparam logic [15:0] WCX_C_NVM_SAVE = 16'h0063;
	localparam logic [15:0] WCX_C_CAL_ZERO = 16'h0064;
	localparam logic [15:0] WCX_C_CAL_FIRST = 16'h0065;
	localparam logic [15:0] WCX_C_SW_RD = 16'h0066;
	localparam logic [15:0] WCX_C_SW_WR = 16'h0067;
	localparam logic [15:0] WCX_C_CAL_CANCEL = 16'h0068;
	localparam logic [15:0] WCX_C_CAL_ADD = 16'h006a;
	localparam logic [15:0] WCX_C_ID_SEND = 16'h0078;
	localparam logic [15:0] WCX_C_PW_SEND = 16'h0079;
	localparam logic [15:0] WCX_C_SEED_RD = 16'h007a;
	localparam logic [15:0] WCX_C_ID_RD = 16'h007b;
	localparam logic [15:0] WCX_C_ID_WR = 16'h007c;
	localparam logic [15:0] WCX_C_PT_EN = 16'h0082;

	typedef enum logic [2:0] {
		WCX_ACC_IDLE,
		WCX_ACC_ID,
		WCX_ACC_SEED,
		WCX_ACC_PW,
		WCX_ACC_GRANTED
	} wcx_acc_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} wcx_bus_t;

	typedef struct packed {
		logic signed [31:0] gross;
		logic signed [31:0] net;
		logic signed [31:0] peak;
	} wcx_weigh_t;

	typedef struct packed {
		logic [31:0] full_scale;
		logic [31:0] max_cap;
		logic [31:0] division;
	} wcx_scale_t;

	typedef struct packed {
		logic keypad_lock;
		logic display_lock;
		logic net_mode;
		logic preset_tare_en;
	} wcx_ctrl_t;

	typedef struct packed {
		logic tare;
		logic zero;
		logic nvm_save;
		logic cal_zero;
		logic cal_point;
		logic cal_first;
		logic cal_cancel;
	} wcx_pulse_t;

	typedef struct packed {
		logic [31:0] sp1;
		logic [31:0] sp2;
		logic [31:0] sp3;
	} wcx_setpoints_t;

endpackage

// ==== rtl/wcx_cal_table.sv ====
`timescale 1ns/1ps
module wcx_cal_table (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic first_i,
	input wire logic add_i,
	input wire logic cancel_i,
	input wire logic [31:0] weight_i,
	output logic ok_o,
	output logic reject_o,
	output logic [3:0] count_o
);
	import wcx_pkg::*;

	logic [31:0] point [WCX_CAL_POINTS];
	logic [WCX_CAL_POINTS-1:0] used;
	logic [WCX_CAL_POINTS-1:0] dup;
	logic [WCX_CAL_POINTS-1:0] slot_first;
	wire is_zero = (weight_i == 32'h0000_0000);
	wire full = &used;
	wire any_dup = |dup;
	// A first point clears the table, so only zero weight can refuse it.
	wire take_first = first_i && !is_zero;
	wire take_add = add_i && !is_zero && !any_dup && !full;

	genvar i;
	generate
		for (i = 0; i < WCX_CAL_POINTS; i = i + 1) begin : g_pt
			assign dup[i] = used[i] && (point[i] == weight_i);
			if (i == 0) begin : g_f
				assign slot_first[i] = !used[i];
			end else begin : g_n
				assign slot_first[i] = !used[i] && (&used[i-1:0]);
			end
			always_ff @(posedge mclk_i) begin
				if (!rstn_i || cancel_i) begin
					used[i] <= 1'b0;
				end else if (take_first) begin
					used[i] <= (i == 0);
				end else if (take_add && slot_first[i]) begin
					used[i] <= 1'b1;
				end
			end
			always_ff @(posedge mclk_i) begin
				if (!rstn_i) begin
					point[i] <= 32'h0000_0000;
				end else if ((take_first && i == 0) ||
					(take_add && slot_first[i])) begin
					point[i] <= weight_i;
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk_i) begin
		if (!rstn_i || cancel_i) begin
			ok_o <= 1'b0;
			reject_o <= 1'b0;
			count_o <= 4'h0;
		end else begin
			ok_o <= take_first || take_add;
			reject_o <= (first_i && !take_first) ||
				(add_i && !take_add);
			if (take_first) begin
				count_o <= 4'h1;
			end else if (take_add) begin
				count_o <= count_o + 4'h1;
			end
		end
	end
endmodule

// ==== rtl/wcx_command_unit.sv ====
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Contract
// - Flag 110% full scale and max+9 divisions.
// - Flag gross beyond plus or minus 999999.
// - Flag net out of range, weight below -20e.
// - Sign flags for gross, net, peak.
// - Flags for net display, stability, near zero.
// - Toggle alive bit once per second.
// - Code zero is no command, separates repeats.
// - Codes 21, 22, 23 lock and unlock.
// - Read codes load the read exchange register.
// - Write codes store the write exchange value.
// - Codes 90-92 read, 93-95 write setpoints.
// - Setpoints volatile; code 99 saves to memory.
// - Preset tare: 88 writes, 87 reads, 130 enables.
// - Calibration and id write need qualified access.
// - Seed read returns zero once access granted.
// - Access is revoked at power-on reset.
// - 100 zeroes, 103 sets sample, 101 first point.
// - 106 appends a calibration point.
// - At most 8 points, no repeats, no zero.
// - Sample weight reads zero after successful save.
// - 104 cancels real calibration, zero kept.
// - Exchange value is 32-bit two's complement.
module wcx_command_unit #(
	parameter int ALIVE_CYCLES = wcx_pkg::WCX_ALIVE_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire wcx_pkg::wcx_bus_t bus_i,
	output logic [31:0] rdata_o,
	input wire wcx_pkg::wcx_weigh_t weigh_i,
	input wire wcx_pkg::wcx_scale_t scale_i,
	input wire logic cell_err_i,
	input wire logic adc_err_i,
	input wire logic stable_i,
	output wcx_pkg::wcx_ctrl_t ctrl_o,
	output wcx_pkg::wcx_pulse_t pulse_o,
	output wcx_pkg::wcx_setpoints_t setpoint_o,
	output logic [31:0] preset_tare_o,
	output logic [31:0] cal_weight_o,
	output logic [15:0] status_o
);
	import wcx_pkg::*;

	logic [15:0] cmd;
	logic [15:0] last_cmd;
	logic [31:0] wx;
	logic [31:0] rx;
	logic [31:0] sample;
	logic [31:0] id_code;
	logic [31:0] user_id;
	logic [31:0] pw;
	logic [31:0] seed;
	logic [31:0] seed_ctr;
	logic [31:0] alive_cnt;
	logic cal_reject;
	wcx_acc_t acc;
	wcx_acc_t next_acc;
	logic [31:0] next_rx;
	logic [3:0] cal_count;
	logic cal_ok;
	logic cal_rej;

	// Bus decode.
	wire wr_cmd = bus_i.wr && (bus_i.addr == WCX_OFS_CMD);
	wire wr_wx = bus_i.wr && (bus_i.addr == WCX_OFS_WX);

	// A command fires once, the cycle after the register takes a new code.
	wire go = (cmd != last_cmd) && (cmd != WCX_C_NONE);
	wire granted = (acc == WCX_ACC_GRANTED);
	wire c_tare_on = go && (cmd == WCX_C_TARE_ON);
	wire c_zero = go && (cmd == WCX_C_ZERO);
	wire c_tare_off = go && (cmd == WCX_C_TARE_OFF);
	wire c_key = go && (cmd == WCX_C_KEY_LOCK);
	wire c_unlock = go && (cmd == WCX_C_UNLOCK);
	wire c_all = go && (cmd == WCX_C_ALL_LOCK);
	wire c_pt_wr = go && (cmd == WCX_C_PT_WR);
	wire c_pt_en = go && (cmd == WCX_C_PT_EN);
	wire c_sp1_wr = go && (cmd == WCX_C_SP1_WR);
	wire c_sp2_wr = go && (cmd == WCX_C_SP2_WR);
	wire c_sp3_wr = go && (cmd == WCX_C_SP3_WR);
	wire c_nvm = go && (cmd == WCX_C_NVM_SAVE);
	wire c_sw_wr = go && (cmd == WCX_C_SW_WR);
	wire c_id_send = go && (cmd == WCX_C_ID_SEND);
	wire c_pw_send = go && (cmd == WCX_C_PW_SEND);
	wire c_id_wr = go && (cmd == WCX_C_ID_WR);
	wire c_cal_zero = go && granted && (cmd == WCX_C_CAL_ZERO);
	wire c_cal_first = go && granted && (cmd == WCX_C_CAL_FIRST);
	wire c_cal_cancel = go && granted && (cmd == WCX_C_CAL_CANCEL);
	wire c_cal_add = go && granted && (cmd == WCX_C_CAL_ADD);

	// The expected password mixes the user code with the seed.
	wire [31:0] expect_pw = user_id ^ seed ^ WCX_ACCESS_KEY;

	// Status conditions on sign-extended weights.
	wire signed [39:0] g = {{8{weigh_i.gross[31]}}, weigh_i.gross};
	wire signed [39:0] n = {{8{weigh_i.net[31]}}, weigh_i.net};
	wire [39:0] fs = {8'h00, scale_i.full_scale};
	wire [39:0] mx = {8'h00, scale_i.max_cap};
	wire [39:0] dv = {8'h00, scale_i.division};
	wire signed [39:0] g10 = signed'(40'(g * signed'(WCX_FS_DEN)));
	wire signed [39:0] fs11 = signed'(40'(fs * WCX_FS_NUM));
	wire signed [39:0] mx9 = signed'(40'(mx + WCX_MAX_OVER_DIV * dv));
	wire signed [39:0] neg20 = -signed'(40'(WCX_UNDER_DIV * dv));
	wire [39:0] g_abs = g[39] ? 40'(-g) : 40'(g);
	wire [39:0] g_abs4 = 40'(g_abs * WCX_ZERO_QUART);
	wire st_fs110 = g10 > fs11;
	wire st_max9 = g > mx9;
	wire st_grng = (g > WCX_RANGE_MAX) || (g < WCX_RANGE_MIN);
	wire st_nrng = (n > WCX_RANGE_MAX) || (n < WCX_RANGE_MIN);
	wire st_under = g < neg20;
	wire st_zero = g_abs4 <= dv;
	wire alive_tick = (alive_cnt == 32'(ALIVE_CYCLES - 1));

	logic [15:0] next_status;
	always_comb begin
		next_status = 16'h0000;
		next_status[WCX_ST_CELL] = cell_err_i;
		next_status[WCX_ST_ADC] = adc_err_i;
		next_status[WCX_ST_MAX9] = st_max9;
		next_status[WCX_ST_FS110] = st_fs110;
		next_status[WCX_ST_GROSS_RNG] = st_grng;
		next_status[WCX_ST_NET_RNG] = st_nrng;
		next_status[WCX_ST_UNDER] = st_under;
		next_status[WCX_ST_GROSS_NEG] = weigh_i.gross[31];
		next_status[WCX_ST_NET_NEG] = weigh_i.net[31];
		next_status[WCX_ST_PEAK_NEG] = weigh_i.peak[31];
		next_status[WCX_ST_NET_MODE] = ctrl_o.net_mode;
		next_status[WCX_ST_STABLE] = stable_i;
		next_status[WCX_ST_NEAR_ZERO] = st_zero;
		next_status[WCX_ST_ALIVE] = status_o[WCX_ST_ALIVE] ^ alive_tick;
	end

	// Read exchange selection; codes without a read leave it alone.
	always_comb begin
		next_rx = rx;
		if (go) begin
			case (cmd)
				WCX_C_PT_RD: next_rx = preset_tare_o;
				WCX_C_SP1_RD: next_rx = setpoint_o.sp1;
				WCX_C_SP2_RD: next_rx = setpoint_o.sp2;
				WCX_C_SP3_RD: next_rx = setpoint_o.sp3;
				WCX_C_SW_RD: next_rx = sample;
				WCX_C_SEED_RD: next_rx = granted ? 32'h0 : seed;
				WCX_C_ID_RD: next_rx = granted ? id_code : 32'h0;
				default: next_rx = rx;
			endcase
		end
	end

	// Access sequence; an id send or password send out of order drops back to idle, an id write out of order restarts at ID.
	always_comb begin
		next_acc = acc;
		case (acc)
			WCX_ACC_IDLE, WCX_ACC_ID, WCX_ACC_SEED, WCX_ACC_PW: begin
				if (c_id_wr) begin
					next_acc = (acc == WCX_ACC_SEED) ? WCX_ACC_PW : WCX_ACC_ID;
				end else if (c_id_send) begin
					next_acc = (acc == WCX_ACC_ID) ? WCX_ACC_SEED : WCX_ACC_IDLE;
				end else if (c_pw_send) begin
					next_acc = (acc == WCX_ACC_PW && pw == expect_pw) ?
						WCX_ACC_GRANTED : WCX_ACC_IDLE;
				end
			end
			WCX_ACC_GRANTED: next_acc = WCX_ACC_GRANTED;
			default: next_acc = WCX_ACC_IDLE;
		endcase
	end

	// Reset stands for power-on, so a grant never survives it.
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			acc <= WCX_ACC_IDLE;
		end else begin
			acc <= next_acc;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			user_id <= 32'h0;
			pw <= 32'h0;
			id_code <= 32'h0;
			seed <= WCX_SEED_RESET;
			seed_ctr <= 32'h0;
		end else begin
			seed_ctr <= seed_ctr + 32'h1;
			if (c_id_wr && granted) begin
				id_code <= wx;
			end else if (c_id_wr && acc == WCX_ACC_SEED) begin
				pw <= wx;
			end else if (c_id_wr) begin
				user_id <= wx;
			end
			// Forcing bit 0 keeps the seed nonzero, so zero means granted.
			if (c_id_send && acc == WCX_ACC_ID) begin
				seed <= seed_ctr | WCX_SEED_RESET;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			cmd <= WCX_C_NONE;
			last_cmd <= WCX_C_NONE;
			wx <= 32'h0;
			rx <= 32'h0;
		end else begin
			last_cmd <= cmd;
			if (wr_cmd) begin
				cmd <= bus_i.wdata[15:0];
			end
			if (wr_wx) begin
				wx <= bus_i.wdata;
			end
			rx <= next_rx;
		end
	end

	// Setpoints and preset tare live in volatile flops only.
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			setpoint_o <= '0;
			preset_tare_o <= 32'h0;
		end else begin
			if (c_sp1_wr) begin
				setpoint_o.sp1 <= wx;
			end
			if (c_sp2_wr) begin
				setpoint_o.sp2 <= wx;
			end
			if (c_sp3_wr) begin
				setpoint_o.sp3 <= wx;
			end
			if (c_pt_wr) begin
				preset_tare_o <= wx;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			ctrl_o <= '0;
		end else begin
			if (c_key) begin
				ctrl_o.keypad_lock <= 1'b1;
			end else if (c_unlock) begin
				ctrl_o.keypad_lock <= 1'b0;
				ctrl_o.display_lock <= 1'b0;
			end else if (c_all) begin
				ctrl_o.keypad_lock <= 1'b1;
				ctrl_o.display_lock <= 1'b1;
			end
			if (c_tare_on || c_pt_en) begin
				ctrl_o.net_mode <= 1'b1;
			end else if (c_tare_off) begin
				ctrl_o.net_mode <= 1'b0;
			end
			if (c_pt_en) begin
				ctrl_o.preset_tare_en <= 1'b1;
			end else if (c_tare_off || c_tare_on) begin
				ctrl_o.preset_tare_en <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			pulse_o <= '0;
		end else begin
			pulse_o.tare <= c_tare_on;
			pulse_o.zero <= c_zero;
			pulse_o.nvm_save <= c_nvm;
			pulse_o.cal_zero <= c_cal_zero;
			pulse_o.cal_point <= cal_ok;
			pulse_o.cal_first <= c_cal_first;
			pulse_o.cal_cancel <= c_cal_cancel;
		end
	end

	wcx_cal_table u_cal (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.first_i(c_cal_first),
		.add_i(c_cal_add),
		.cancel_i(c_cal_cancel),
		.weight_i(sample),
		.ok_o(cal_ok),
		.reject_o(cal_rej),
		.count_o(cal_count)
	);

	// Cancel clears the points and the reject flag; the calibration zero is left intact.
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			sample <= 32'h0;
			cal_weight_o <= 32'h0;
			cal_reject <= 1'b0;
		end else begin
			if (c_sw_wr) begin
				sample <= wx;
			end else if (cal_ok) begin
				sample <= 32'h0;
			end
			if (c_cal_first || c_cal_add) begin
				cal_weight_o <= sample;
			end
			if (cal_rej) begin
				cal_reject <= 1'b1;
			end else if (cal_ok || c_cal_cancel) begin
				cal_reject <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			alive_cnt <= 32'h0;
			status_o <= 16'h0000;
		end else begin
			alive_cnt <= alive_tick ? 32'h0 : alive_cnt + 32'h1;
			status_o <= next_status;
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		case (bus_i.addr)
			WCX_OFS_CMD: rd_mux = {16'h0000, cmd};
			WCX_OFS_WX: rd_mux = wx;
			WCX_OFS_RX: rd_mux = rx;
			WCX_OFS_STATUS: rd_mux = {16'h0000, status_o};
			WCX_OFS_CALINFO: rd_mux = {15'h0000, granted, 7'h00,
				cal_reject, 4'h0, cal_count};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rdata_o <= 32'h0;
		end else begin
			rdata_o <= bus_i.rd ? rd_mux : 32'h0;
		end
	end
endmodule

// ==== testbench/wcx_master_model.sv ====
`timescale 1ns/1ps
module wcx_master_model (
	input wire logic mclk_i,
	input wire logic [31:0] rdata_i,
	output wcx_pkg::wcx_bus_t bus_o
);
	import wcx_pkg::*;
	initial bus_o = '0;
	// Released address and data are inverted so stale values never match.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		bus_o.addr <= a;
		bus_o.wdata <= d;
		bus_o.wr <= 1'b1;
		@(posedge mclk_i);
		bus_o.wr <= 1'b0;
		bus_o.addr <= ~a;
		bus_o.wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		bus_o.addr <= a;
		bus_o.rd <= 1'b1;
		@(posedge mclk_i);
		bus_o.rd <= 1'b0;
		bus_o.addr <= ~a;
		@(posedge mclk_i);
		d = rdata_i;
	endtask
	// Two idle cycles let a code execute before anything depends on it.
	task automatic cmd(input logic [15:0] c);
		wr(WCX_OFS_CMD, {16'h0000, c});
		repeat (2) @(posedge mclk_i);
	endtask
	task automatic access(input logic [31:0] id, output logic [31:0] res);
		logic [31:0] seed;
		wr(WCX_OFS_WX, id);
		cmd(WCX_C_ID_WR);
		cmd(WCX_C_ID_SEND);
		cmd(WCX_C_SEED_RD);
		rd(WCX_OFS_RX, seed);
		wr(WCX_OFS_WX, id ^ seed ^ WCX_ACCESS_KEY);
		cmd(WCX_C_ID_WR);
		cmd(WCX_C_PW_SEND);
		cmd(WCX_C_SEED_RD);
		rd(WCX_OFS_RX, res);
	endtask
endmodule

// ==== testbench/wcx_command_unit_assertions.sv ====
`timescale 1ns/1ps
module wcx_command_unit_chk #(
	parameter int ALIVE_CYCLES = 16
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire wcx_pkg::wcx_bus_t bus_i,
	input wire logic [31:0] rdata_o,
	input wire wcx_pkg::wcx_weigh_t weigh_i,
	input wire logic stable_i,
	input wire wcx_pkg::wcx_ctrl_t ctrl_o,
	input wire wcx_pkg::wcx_pulse_t pulse_o,
	input wire wcx_pkg::wcx_setpoints_t setpoint_o,
	input wire logic [15:0] status_o
);
	import wcx_pkg::*;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);
	// A code only counts as fresh when it differs from the one held.
	logic [15:0] last_cmd;
	logic [31:0] wx_h;
	logic alive_q;
	logic seen;
	int cnt;
	wire wcmd = bus_i.wr && bus_i.addr == WCX_OFS_CMD;
	wire [15:0] wc = bus_i.wdata[15:0];
	wire fresh = wcmd && wc != last_cmd;
	wire chg = status_o[WCX_ST_ALIVE] != alive_q;
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			last_cmd <= '0;
			wx_h <= '0;
			alive_q <= 1'b0;
			seen <= 1'b0;
			cnt <= 0;
		end else begin
			if (wcmd)
				last_cmd <= wc;
			if (bus_i.wr && bus_i.addr == WCX_OFS_WX)
				wx_h <= bus_i.wdata;
			alive_q <= status_o[WCX_ST_ALIVE];
			seen <= seen || chg;
			cnt <= chg ? 0 : cnt + 1;
		end
	end
	property p_sign;
		$past(rstn_i) |-> status_o[9:7] == {$past(weigh_i.peak[31]),
			$past(weigh_i.net[31]), $past(weigh_i.gross[31])};
	endproperty
	a_sign: assert property (p_sign) else $error("sign flags wrong");
	property p_grng;
		$past(rstn_i) |-> status_o[4] == ($past(weigh_i.gross) > WCX_RANGE_MAX
			|| $past(weigh_i.gross) < WCX_RANGE_MIN);
	endproperty
	a_grng: assert property (p_grng) else $error("gross range bad");
	property p_nrng;
		$past(rstn_i) |-> status_o[5] == ($past(weigh_i.net) > WCX_RANGE_MAX
			|| $past(weigh_i.net) < WCX_RANGE_MIN);
	endproperty
	a_nrng: assert property (p_nrng) else $error("net range bad");
	property p_stable;
		$past(rstn_i) |-> status_o[11] == $past(stable_i);
	endproperty
	a_stable: assert property (p_stable) else $error("stable bad");
	property p_alive;
		chg && seen |-> cnt == ALIVE_CYCLES - 1;
	endproperty
	a_alive: assert property (p_alive) else $error("alive period");
	property p_alive_max;
		cnt <= ALIVE_CYCLES + 1;
	endproperty
	a_alive_max: assert property (p_alive_max) else $error("alive stuck");
	property p_rdata;
		!$past(bus_i.rd) |-> rdata_o == 32'h0;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data stays");
	property p_lock;
		fresh && wc == WCX_C_ALL_LOCK |-> ##2 ctrl_o.keypad_lock
			&& ctrl_o.display_lock;
	endproperty
	a_lock: assert property (p_lock) else $error("lock not set");
	property p_sp1;
		fresh && wc == WCX_C_SP1_WR |-> ##2 setpoint_o.sp1 == $past(wx_h, 2);
	endproperty
	a_sp1: assert property (p_sp1) else $error("setpoint write");
	property p_nvm;
		fresh && wc == WCX_C_NVM_SAVE |-> ##2 pulse_o.nvm_save
			##1 !pulse_o.nvm_save;
	endproperty
	a_nvm: assert property (p_nvm) else $error("save pulse");
	// A fresh code pulses exactly once, then the output falls back.
	property p_zero;
		fresh && wc == WCX_C_ZERO |-> ##2 pulse_o.zero ##1 !pulse_o.zero;
	endproperty
	a_zero: assert property (p_zero) else $error("zero pulse");
endmodule
bind wcx_command_unit wcx_command_unit_chk #(.ALIVE_CYCLES(ALIVE_CYCLES))
	u_chk (.mclk_i, .rstn_i, .bus_i, .rdata_o, .weigh_i, .stable_i,
	.ctrl_o, .pulse_o, .setpoint_o, .status_o);

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import wcx_pkg::*;
	logic mclk_i;
	logic rstn_i;
	wcx_bus_t bus;
	logic [31:0] rdata;
	wcx_weigh_t weigh;
	wcx_scale_t scale;
	logic cell_err;
	logic adc_err;
	logic stable;
	wcx_ctrl_t ctrl;
	wcx_pulse_t pulse;
	wcx_setpoints_t sp;
	logic [31:0] pt;
	logic [31:0] calw;
	logic [15:0] status;
	logic [31:0] d;
	int failures;
	int checked;
	wcx_command_unit #(.ALIVE_CYCLES(16)) dut (.mclk_i(mclk_i),
		.rstn_i(rstn_i), .bus_i(bus), .rdata_o(rdata), .weigh_i(weigh),
		.scale_i(scale), .cell_err_i(cell_err), .adc_err_i(adc_err),
		.stable_i(stable), .ctrl_o(ctrl), .pulse_o(pulse),
		.setpoint_o(sp), .preset_tare_o(pt), .cal_weight_o(calw),
		.status_o(status));
	wcx_master_model m (.mclk_i(mclk_i), .rdata_i(rdata), .bus_o(bus));
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	task automatic chk(input string name, input logic [31:0] exp, got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge mclk_i);
		rstn_i <= 1'b0;
		repeat (12) @(posedge mclk_i);
		rstn_i <= 1'b1;
	endtask
	task automatic reg_chk(string name, logic [7:0] a, logic [31:0] mask,
		logic [31:0] exp);
		m.rd(a, d);
		chk(name, exp, d & mask);
	endtask
	// The alive bit is masked out here; the checker watches its period.
	task automatic stat(logic signed [31:0] g, n, p, logic st,
		logic [15:0] exp);
		@(posedge mclk_i);
		weigh <= '{g, n, p};
		stable <= st;
		repeat (2) @(posedge mclk_i);
		reg_chk("status", WCX_OFS_STATUS, 32'h7fff, {16'h0000, exp});
	endtask
	task automatic cal(logic [31:0] v, logic [15:0] code);
		m.wr(WCX_OFS_WX, v);
		m.cmd(WCX_C_SW_WR);
		m.cmd(code);
	endtask
	initial begin
		rstn_i = 1'b0;
		cell_err = 1'b0;
		adc_err = 1'b0;
		stable = 1'b0;
		weigh = '{32'sd100, 32'sd100, 32'sd100};
		scale = '{32'd1000, 32'd1000, 32'd1};
		do_reset();
		reg_chk("status_rst", WCX_OFS_STATUS, 32'h7fff, 32'h0);
		reg_chk("calinfo_rst", WCX_OFS_CALINFO, '1, 32'h0);
		reg_chk("unmapped", 8'h20, '1, 32'h0);
		stat(1101, 100, 100, 0, 16'h000c);
		stat(1100, 100, 100, 0, 16'h0004);
		stat(-1000000, -1000000, -1, 0, 16'h03f0);
		stat(0, 999999, 0, 1, 16'h1800);
		cell_err <= 1'b1;
		adc_err <= 1'b1;
		stat(-21, 5, 5, 0, 16'h00c3);
		for (int i = 0; i < 3; i++) begin
			m.wr(WCX_OFS_WX, 32'h100 + i);
			m.cmd(16'(WCX_C_SP1_WR + i));
			m.cmd(16'(WCX_C_SP1_RD + i));
			reg_chk("sp_rx", WCX_OFS_RX, '1, 32'h100 + i);
		end
		chk("sp1", 32'h100, sp.sp1);
		chk("sp3", 32'h102, sp.sp3);
		m.wr(WCX_OFS_WX, 32'h777);
		m.cmd(WCX_C_SP3_WR);
		m.wr(WCX_OFS_WX, 32'h888);
		m.cmd(WCX_C_SP3_WR);
		chk("sp3_repeat", 32'h777, sp.sp3);
		m.cmd(WCX_C_NONE);
		m.cmd(WCX_C_SP3_WR);
		chk("sp3_after0", 32'h888, sp.sp3);
		m.cmd(WCX_C_NVM_SAVE);
		m.cmd(16'd200);
		chk("undefined", 32'h888, sp.sp3);
		m.wr(WCX_OFS_WX, 32'hffff_ffc8);
		m.cmd(WCX_C_PT_WR);
		chk("ptare", 32'hffff_ffc8, pt);
		m.cmd(WCX_C_PT_RD);
		reg_chk("ptare_rx", WCX_OFS_RX, '1, 32'hffff_ffc8);
		m.cmd(WCX_C_PT_EN);
		chk("pt_en", 32'h3, {30'h0, ctrl.net_mode, ctrl.preset_tare_en});
		reg_chk("net_mode", WCX_OFS_STATUS, 32'h0400, 32'h0400);
		m.cmd(WCX_C_TARE_OFF);
		reg_chk("gross_mode", WCX_OFS_STATUS, 32'h0400, 32'h0);
		m.cmd(WCX_C_TARE_ON);
		chk("tare_on", 32'h2, {30'h0, ctrl.net_mode, ctrl.preset_tare_en});
		m.cmd(WCX_C_ZERO);
		m.cmd(WCX_C_KEY_LOCK);
		chk("lock21", 32'h2, {30'h0, ctrl.keypad_lock, ctrl.display_lock});
		m.cmd(WCX_C_ALL_LOCK);
		chk("lock23", 32'h3, {30'h0, ctrl.keypad_lock, ctrl.display_lock});
		m.cmd(WCX_C_UNLOCK);
		chk("lock22", 32'h0, {30'h0, ctrl.keypad_lock, ctrl.display_lock});
		cal(32'd500, WCX_C_CAL_FIRST);
		reg_chk("cal_gated", WCX_OFS_CALINFO, 32'hf, 32'h0);
		m.access(32'h1234, d);
		chk("seed_after", 32'h0, d);
		reg_chk("granted", WCX_OFS_CALINFO, 32'h1_0000, 32'h1_0000);
		m.wr(WCX_OFS_WX, 32'h0000_0abc);
		m.cmd(WCX_C_ID_WR);
		m.cmd(WCX_C_ID_RD);
		reg_chk("id_code", WCX_OFS_RX, '1, 32'h0000_0abc);
		m.cmd(WCX_C_CAL_ZERO);
		cal(32'd500, WCX_C_CAL_FIRST);
		chk("cal_weight", 32'd500, calw);
		m.cmd(WCX_C_SW_RD);
		reg_chk("sample_rd", WCX_OFS_RX, '1, 32'h0);
		cal(32'd500, WCX_C_CAL_ADD);
		cal(32'd0, WCX_C_CAL_ADD);
		reg_chk("rejects", WCX_OFS_CALINFO, 32'h10f, 32'h101);
		for (int k = 1; k < 8; k++)
			cal(32'(-56 * k), WCX_C_CAL_ADD);
		reg_chk("count8", WCX_OFS_CALINFO, 32'hf, 32'h8);
		cal(32'd900, WCX_C_CAL_ADD);
		reg_chk("full", WCX_OFS_CALINFO, 32'h10f, 32'h108);
		m.cmd(WCX_C_CAL_CANCEL);
		reg_chk("cancel", WCX_OFS_CALINFO, 32'hf, 32'h0);
		do_reset();
		reg_chk("revoked", WCX_OFS_CALINFO, '1, 32'h0);
		chk("sp_lost", 32'h0, sp.sp3);
		conclude();
	end
	initial begin
		#400000;
		failures++;
		conclude();
	end
endmodule
